/* File: core/icf_params.svh */
`ifndef ICF_PARAMS_SVH
`define ICF_PARAMS_SVH

// register indices; byte address is four times the index
`define ICF_IDX_W          10
`define ICF_IDX_OSC_CFG    10'h300
`define ICF_IDX_OSC_AMP    10'h301
`define ICF_IDX_OSC_TRIM   10'h302
`define ICF_IDX_IC1_CFG    10'h303
`define ICF_IDX_IC2_CFG    10'h304
`define ICF_IDX_IC3_CFG    10'h305

// bus geometry
`define ICF_ADR_W          12
`define ICF_ADR_IDX_LSB    2
`define ICF_BYTE_LANE      0

// input configuration byte layout
`define ICF_BIT_EDGE_SEL   6
`define ICF_BIT_FEED_DIS   5
`define ICF_WIN_LSB        2
`define ICF_WIN_MSB        4
`define ICF_DIV_LSB        0
`define ICF_DIV_MSB        1
`define ICF_CFG_MASK       8'h7F

// load trim layout
`define ICF_TRIM_LO_LSB    0
`define ICF_TRIM_LO_MSB    3
`define ICF_TRIM_HI_LSB    4
`define ICF_TRIM_HI_MSB    7

// values
`define ICF_RST_BYTE       8'h00
`define ICF_OSC_DIV2       2'h1
`define ICF_MISS_LIMIT     64
`define ICF_NUM_IN         4

`endif

/* File: core/icf_pkg.sv */
`include "icf_params.svh"

package icf_pkg;

  typedef logic [7:0] icf_byte_t;

  typedef enum logic [2:0] {
    ICF_WIN_1    = 3'h0,
    ICF_WIN_4    = 3'h1,
    ICF_WIN_16   = 3'h2,
    ICF_WIN_64   = 3'h3,
    ICF_WIN_256  = 3'h4,
    ICF_WIN_1024 = 3'h5
  } icf_win_t;

  // unused codes take the longest window: safest, never validates early
  function automatic logic [10:0] icf_win_len(input logic [2:0] code);
    case (code)
      ICF_WIN_1:   icf_win_len = 11'h001;
      ICF_WIN_4:   icf_win_len = 11'h004;
      ICF_WIN_16:  icf_win_len = 11'h010;
      ICF_WIN_64:  icf_win_len = 11'h040;
      ICF_WIN_256: icf_win_len = 11'h100;
      default:     icf_win_len = 11'h400;
    endcase
  endfunction : icf_win_len

  // divisor minus one; oscillator path knows only /1 and /2
  function automatic logic [2:0] icf_div_mask(input logic [1:0] code, input logic is_osc);
    if (is_osc) begin
      icf_div_mask = (code == `ICF_OSC_DIV2) ? 3'h1 : 3'h0;
    end else begin
      case (code)
        2'h0:    icf_div_mask = 3'h0;
        2'h1:    icf_div_mask = 3'h1;
        2'h2:    icf_div_mask = 3'h3;
        default: icf_div_mask = 3'h7;
      endcase
    end
  endfunction : icf_div_mask

endpackage : icf_pkg

/* File: core/icf_input_channel.sv */
`timescale 1ns/1ps
`include "icf_params.svh"

module icf_input_channel #(
  parameter int MISS_LIMIT = `ICF_MISS_LIMIT,
  parameter bit IS_OSC     = 1'b0
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       pin_i,
  input  wire logic [7:0] cfg_i,
  output logic            lock_edge_o,
  output logic            monitor_edge_o,
  output logic            input_valid_o
);

  localparam int GW = $clog2(MISS_LIMIT + 1);
  localparam logic [GW-1:0] MISS_C = GW'(MISS_LIMIT);

  typedef struct packed {
    logic          s1;
    logic          s2;
    logic          prev;
    logic [2:0]    warm;
    logic [2:0]    pre_cnt;
    logic [GW-1:0] gap;
    logic [10:0]   run;
    logic          valid;
    logic          lock_edge;
    logic          mon_edge;
  } icf_ch_st_t;

  icf_ch_st_t st_r;
  icf_ch_st_t st_nxt;
  logic       rise_w;
  logic       fall_w;
  logic       armed_w;
  logic       sel_w;
  logic       fed_w;
  logic       pol_w;
  logic       dis_w;
  logic [2:0] mask_w;
  logic [10:0] need_w;

  assign pol_w  = cfg_i[`ICF_BIT_EDGE_SEL];
  assign dis_w  = cfg_i[`ICF_BIT_FEED_DIS];
  assign mask_w = icf_pkg::icf_div_mask(cfg_i[`ICF_DIV_MSB:`ICF_DIV_LSB], IS_OSC);
  assign need_w = icf_pkg::icf_win_len(cfg_i[`ICF_WIN_MSB:`ICF_WIN_LSB]);
  // edges count only once all sampling flops hold real pin samples,
  // so a pin that idles high shows no false rise after reset
  assign armed_w = st_r.warm[2];
  assign rise_w = st_r.s2 & ~st_r.prev & armed_w;
  assign fall_w = ~st_r.s2 & st_r.prev & armed_w;
  assign sel_w  = pol_w ? fall_w : rise_w;
  assign fed_w  = sel_w & ~dis_w;

  always_comb begin
    st_nxt           = st_r;
    st_nxt.s1        = pin_i;
    st_nxt.s2        = st_r.s1;
    st_nxt.prev      = st_r.s2;
    st_nxt.warm      = {st_r.warm[1:0], 1'b1};
    st_nxt.lock_edge = 1'b0;
    st_nxt.mon_edge  = fed_w;
    // >= keeps the divider sane when a smaller ratio is written mid-count
    if (sel_w) begin
      if (st_r.pre_cnt >= mask_w) begin
        st_nxt.pre_cnt   = 3'h0;
        st_nxt.lock_edge = 1'b1;
      end else begin
        st_nxt.pre_cnt = st_r.pre_cnt + 3'h1;
      end
    end
    if (fed_w) begin
      st_nxt.gap = '0;
      if (st_r.run < need_w) begin
        st_nxt.run = st_r.run + 11'h001;
      end
    end else if (st_r.gap < MISS_C) begin
      st_nxt.gap = st_r.gap + GW'(1);
    end else begin
      st_nxt.run = 11'h000;
    end
    st_nxt.valid = (st_nxt.run >= need_w);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lock_edge_o    = st_r.lock_edge;
  assign monitor_edge_o = st_r.mon_edge;
  assign input_valid_o  = st_r.valid;

  property p_rise_lock;
    @(posedge clk_i) disable iff (rst_i) (rise_w && !pol_w && mask_w == 3'h0) |=> lock_edge_o;
  endproperty
  a_rise_lock: assert property (p_rise_lock) else $error("rising edge not passed");

  property p_fall_lock;
    @(posedge clk_i) disable iff (rst_i) (fall_w && pol_w && mask_w == 3'h0) |=> lock_edge_o;
  endproperty
  a_fall_lock: assert property (p_fall_lock) else $error("falling edge not passed");

  property p_no_edge;
    @(posedge clk_i) disable iff (rst_i) !sel_w |=> (!lock_edge_o && !monitor_edge_o);
  endproperty
  a_no_edge: assert property (p_no_edge) else $error("edge pulse without edge");

  property p_feed_off;
    @(posedge clk_i) disable iff (rst_i) dis_w |=> !monitor_edge_o;
  endproperty
  a_feed_off: assert property (p_feed_off) else $error("monitor fed while disabled");

  property p_miss;
    @(posedge clk_i) disable iff (rst_i) (st_r.gap == MISS_C && !fed_w) |=> !input_valid_o;
  endproperty
  a_miss: assert property (p_miss) else $error("valid after missing edge");

  property p_valid_run;
    @(posedge clk_i) disable iff (rst_i) input_valid_o |-> $past(st_nxt.run) >= $past(need_w);
  endproperty
  a_valid_run: assert property (p_valid_run) else $error("valid before window filled");

endmodule : icf_input_channel

/* File: core/icf_input_front.sv */
`timescale 1ns/1ps
`include "icf_params.svh"

// Operation
// - edge-select bit: 0 locks to rising edge, 1 to falling edge, every input
// - monitor-feed-disable at 1 withholds the input from its monitor; 0 passes it
// - input valid only after no missed edge over the whole validation window
// - window codes 0..5 mean 1,4,16,64,256,1024 fed edges; 6 and 7 unused
// - oscillator prescale: code 00 divides by 1, 01 by 2, others unused
// - clock input prescale codes 00..11 divide by 1, 2, 4, 8
// - eight-bit crystal amplifier setting is held and driven to the crystal driver
// - upper and lower trim nibbles set second and first oscillator pin capacitance

module icf_input_front #(
  parameter int MISS_LIMIT = `ICF_MISS_LIMIT
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // classic wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [`ICF_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // reference pins, asynchronous to clk_i
  input  wire logic                  oscillator_input_pin_i,
  input  wire logic [2:0]            reference_clock_input_n_i,
  // doubler enable from the clock control register, same clock
  input  wire logic                  oscillator_doubler_enable_i,
  // towards the synthesizer pll and monitors; bit 0 is the oscillator
  output logic [`ICF_NUM_IN-1:0]     lock_edge_o,
  output logic [`ICF_NUM_IN-1:0]     monitor_edge_o,
  output logic [`ICF_NUM_IN-1:0]     input_valid_o,
  // towards the crystal driver
  output logic [7:0]                 crystal_amp_setting_o,
  output logic [3:0]                 first_pin_load_trim_o,
  output logic [3:0]                 second_pin_load_trim_o,
  output logic                       prescale_doubler_conflict_o
);

  // ===========================================================================
  // state
  // ===========================================================================

  typedef struct packed {
    logic                                   ack;
    icf_pkg::icf_byte_t                     rdat;
    logic [`ICF_NUM_IN-1:0][7:0]            cfg;
    icf_pkg::icf_byte_t                     amp;
    icf_pkg::icf_byte_t                     trim;
    logic                                   conflict;
  } icf_front_st_t;

  icf_front_st_t             st_r;
  icf_front_st_t             st_nxt;
  logic                      req_w;
  logic                      wr_w;
  logic                      rd_w;
  logic [`ICF_IDX_W-1:0]     idx_w;
  logic [`ICF_NUM_IN-1:0]    pin_w;

  // ===========================================================================
  // decode helpers
  // ===========================================================================

  function automatic logic icf_mapped(input logic [`ICF_IDX_W-1:0] idx);
    icf_mapped = (idx >= `ICF_IDX_OSC_CFG) && (idx <= `ICF_IDX_IC3_CFG);
  endfunction : icf_mapped

  // unmapped indices read zero
  function automatic icf_pkg::icf_byte_t icf_read(input logic [`ICF_IDX_W-1:0] idx,
                                                  input icf_front_st_t s);
    case (idx)
      `ICF_IDX_OSC_CFG:  icf_read = s.cfg[0];
      `ICF_IDX_OSC_AMP:  icf_read = s.amp;
      `ICF_IDX_OSC_TRIM: icf_read = s.trim;
      `ICF_IDX_IC1_CFG:  icf_read = s.cfg[1];
      `ICF_IDX_IC2_CFG:  icf_read = s.cfg[2];
      `ICF_IDX_IC3_CFG:  icf_read = s.cfg[3];
      default:           icf_read = `ICF_RST_BYTE;
    endcase
  endfunction : icf_read

  assign idx_w = wb_adr_i[`ICF_ADR_W-1:`ICF_ADR_IDX_LSB];
  // one-wait-state slave: request taken while ack is low, answered next edge
  assign req_w = wb_cyc_i & wb_stb_i & ~st_r.ack;
  assign wr_w  = req_w & wb_we_i & wb_sel_i[`ICF_BYTE_LANE];
  assign rd_w  = req_w & ~wb_we_i;

  // ===========================================================================
  // register file
  // ===========================================================================

  always_comb begin
    st_nxt      = st_r;
    st_nxt.ack  = req_w;
    st_nxt.rdat = `ICF_RST_BYTE;
    if (rd_w) begin
      st_nxt.rdat = icf_read(idx_w, st_r);
    end
    if (wr_w) begin
      case (idx_w)
        `ICF_IDX_OSC_CFG: begin
          st_nxt.cfg[0] = wb_dat_i[7:0] & `ICF_CFG_MASK;
        end
        `ICF_IDX_OSC_AMP: begin
          st_nxt.amp = wb_dat_i[7:0];
        end
        `ICF_IDX_OSC_TRIM: begin
          st_nxt.trim = wb_dat_i[7:0];
        end
        `ICF_IDX_IC1_CFG: begin
          st_nxt.cfg[1] = wb_dat_i[7:0] & `ICF_CFG_MASK;
        end
        `ICF_IDX_IC2_CFG: begin
          st_nxt.cfg[2] = wb_dat_i[7:0] & `ICF_CFG_MASK;
        end
        `ICF_IDX_IC3_CFG: begin
          st_nxt.cfg[3] = wb_dat_i[7:0] & `ICF_CFG_MASK;
        end
        default: begin
          st_nxt.cfg = st_r.cfg;
        end
      endcase
    end
    // flag only; the divider still obeys the field, software owns the fix
    st_nxt.conflict = (st_r.cfg[0][`ICF_DIV_MSB:`ICF_DIV_LSB] == `ICF_OSC_DIV2)
                      & oscillator_doubler_enable_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ===========================================================================
  // outputs
  // ===========================================================================

  assign wb_dat_o                    = {24'h000000, st_r.rdat};
  assign wb_ack_o                    = st_r.ack;
  assign crystal_amp_setting_o       = st_r.amp;
  assign first_pin_load_trim_o       = st_r.trim[`ICF_TRIM_LO_MSB:`ICF_TRIM_LO_LSB];
  assign second_pin_load_trim_o      = st_r.trim[`ICF_TRIM_HI_MSB:`ICF_TRIM_HI_LSB];
  assign prescale_doubler_conflict_o = st_r.conflict;

  // ===========================================================================
  // input channels
  // ===========================================================================

  assign pin_w = {reference_clock_input_n_i, oscillator_input_pin_i};

  generate
    for (genvar g = 0; g < `ICF_NUM_IN; g++) begin : g_ch
      icf_input_channel #(
        .MISS_LIMIT (MISS_LIMIT),
        .IS_OSC     (g == 0)
      ) u_ch (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .pin_i          (pin_w[g]),
        .cfg_i          (st_r.cfg[g]),
        .lock_edge_o    (lock_edge_o[g]),
        .monitor_edge_o (monitor_edge_o[g]),
        .input_valid_o  (input_valid_o[g])
      );
    end
  endgenerate

  // ===========================================================================
  // assertions
  // ===========================================================================

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_wr_amp;
    s_req and (wb_we_i && wb_sel_i[0] && idx_w == `ICF_IDX_OSC_AMP);
  endsequence

  sequence s_wr_trim;
    s_req and (wb_we_i && wb_sel_i[0] && idx_w == `ICF_IDX_OSC_TRIM);
  endsequence

  sequence s_rd_unmapped;
    s_req and (!wb_we_i && !icf_mapped(idx_w));
  endsequence

  property p_ack_resp;
    @(posedge clk_i) disable iff (rst_i) s_req |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack one cycle after request");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

  property p_amp_wr;
    @(posedge clk_i) disable iff (rst_i)
      s_wr_amp |=> (crystal_amp_setting_o == $past(wb_dat_i[7:0]));
  endproperty
  a_amp_wr: assert property (p_amp_wr) else $error("amplifier setting not stored");

  property p_trim_wr;
    @(posedge clk_i) disable iff (rst_i)
      s_wr_trim |=> ({second_pin_load_trim_o, first_pin_load_trim_o} == $past(wb_dat_i[7:0]));
  endproperty
  a_trim_wr: assert property (p_trim_wr) else $error("trim nibbles misplaced");

  property p_rd_high_zero;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |-> (wb_dat_o[31:8] == 24'h000000);
  endproperty
  a_rd_high_zero: assert property (p_rd_high_zero) else $error("upper read bits not zero");

  property p_rd_unmapped;
    @(posedge clk_i) disable iff (rst_i) s_rd_unmapped |=> (wb_dat_o == 32'h00000000);
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

  property p_reserved;
    @(posedge clk_i) disable iff (rst_i)
      (st_r.cfg[0][7] == 1'b0) && (st_r.cfg[1][7] == 1'b0) &&
      (st_r.cfg[2][7] == 1'b0) && (st_r.cfg[3][7] == 1'b0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit stored");

  property p_conflict;
    @(posedge clk_i) disable iff (rst_i)
      (st_r.cfg[0][1:0] == `ICF_OSC_DIV2 && oscillator_doubler_enable_i) |=> prescale_doubler_conflict_o;
  endproperty
  a_conflict: assert property (p_conflict) else $error("conflict flag missing");

  property p_rd_back;
    @(posedge clk_i) disable iff (rst_i)
      (s_req and (!wb_we_i && idx_w == `ICF_IDX_OSC_AMP)) |=> (wb_dat_o[7:0] == crystal_amp_setting_o);
  endproperty
  a_rd_back: assert property (p_rd_back) else $error("amplifier read back wrong");

  sequence s_wr_osc_cfg;
    s_req and (wb_we_i && wb_sel_i[`ICF_BYTE_LANE] && idx_w == `ICF_IDX_OSC_CFG);
  endsequence

  sequence s_wr_no_lane;
    s_req and (wb_we_i && !wb_sel_i[`ICF_BYTE_LANE]);
  endsequence

  sequence s_rd_trim;
    s_req and (!wb_we_i && idx_w == `ICF_IDX_OSC_TRIM);
  endsequence

  sequence s_rd_last_cfg;
    s_req and (!wb_we_i && idx_w == `ICF_IDX_IC3_CFG);
  endsequence

  property p_cfg_wr;
    @(posedge clk_i) disable iff (rst_i)
      s_wr_osc_cfg |=> (st_r.cfg[0] == ($past(wb_dat_i[7:0]) & `ICF_CFG_MASK));
  endproperty
  a_cfg_wr: assert property (p_cfg_wr) else $error("config not stored");

  property p_lane_off;
    @(posedge clk_i) disable iff (rst_i)
      s_wr_no_lane |=> ($stable(st_r.cfg) && $stable(st_r.amp) && $stable(st_r.trim));
  endproperty
  a_lane_off: assert property (p_lane_off) else $error("write without lane landed");

  property p_rd_trim;
    @(posedge clk_i) disable iff (rst_i)
      s_rd_trim |=> (wb_dat_o[7:0] == {second_pin_load_trim_o, first_pin_load_trim_o});
  endproperty
  a_rd_trim: assert property (p_rd_trim) else $error("trim read back wrong");

  property p_rd_cfg;
    @(posedge clk_i) disable iff (rst_i)
      s_rd_last_cfg |=> (wb_dat_o[7:0] == st_r.cfg[3]);
  endproperty
  a_rd_cfg: assert property (p_rd_cfg) else $error("config read back wrong");

  property p_rd_idle;
    @(posedge clk_i) disable iff (rst_i)
      !wb_ack_o |-> (wb_dat_o == 32'h00000000);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside an answer");

  property p_ack_cause;
    @(posedge clk_i) disable iff (rst_i)
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");

  property p_amp_hold;
    @(posedge clk_i) disable iff (rst_i)
      !wr_w |=> $stable(crystal_amp_setting_o);
  endproperty
  a_amp_hold: assert property (p_amp_hold) else $error("amplifier changed without write");

  property p_trim_hold;
    @(posedge clk_i) disable iff (rst_i)
      !wr_w |=> ($stable(first_pin_load_trim_o) && $stable(second_pin_load_trim_o));
  endproperty
  a_trim_hold: assert property (p_trim_hold) else $error("trim changed without write");

  property p_conflict_clear;
    @(posedge clk_i) disable iff (rst_i)
      (st_r.cfg[0][`ICF_DIV_MSB:`ICF_DIV_LSB] != `ICF_OSC_DIV2) |=> !prescale_doubler_conflict_o;
  endproperty
  a_conflict_clear: assert property (p_conflict_clear) else $error("conflict flag without cause");

  // not disabled by reset: the register file must be clear on the edge after it
  property p_reset_clear;
    @(posedge clk_i) rst_i |=> (st_r == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("registers not cleared by reset");

  // ===========================================================================
  // channel assertions
  // ===========================================================================

  generate
    for (genvar g = 0; g < `ICF_NUM_IN; g++) begin : g_chk
      property p_feed_gate;
        @(posedge clk_i) disable iff (rst_i)
          st_r.cfg[g][`ICF_BIT_FEED_DIS] |=> !monitor_edge_o[g];
      endproperty
      a_feed_gate: assert property (p_feed_gate) else $error("disabled input fed its monitor");

      property p_div1_lock;
        @(posedge clk_i) disable iff (rst_i)
          (monitor_edge_o[g] && $past(st_r.cfg[g][`ICF_DIV_MSB:`ICF_DIV_LSB]) == 2'h0) |-> lock_edge_o[g];
      endproperty
      a_div1_lock: assert property (p_div1_lock) else $error("monitored edge not passed on");
    end
  endgenerate

endmodule : icf_input_front

/* File: tb/icf_ref_sources.sv */
`timescale 1ns/1ps

// =====================================================================
// reference sources: oscillator on bit 0, clock inputs 1..3 on bits 1..3
// =====================================================================
module icf_ref_sources (
  input  wire logic [3:0] run_i,
  output logic      [3:0] pins_o
);
  // periods of 7 to 10.5 system clocks: well inside the missing-edge limit,
  // slower than clk/2, and unrelated in phase to clk_i
  localparam int HALF_NS [4] = '{87, 101, 113, 131};

  logic [3:0] lvl = 4'h0;

  assign pins_o = lvl;

  // a stopped source stands still at its last level
  for (genvar g = 0; g < 4; g++) begin : g_src
    initial begin
      forever begin
        #(HALF_NS[g]);
        if (run_i[g] === 1'b1) begin
          lvl[g] = ~lvl[g];
        end
      end
    end
  end

  // single edge on demand, for polarity checks while the source is stopped
  task automatic flip(input int k);
    lvl[k] = ~lvl[k];
  endtask : flip
endmodule : icf_ref_sources

/* File: tb/icf_input_front_bench.sv */
`timescale 1ns/1ps
`include "icf_params.svh"

module icf_input_front_bench;
  localparam int MISS = 16;

  logic        clk_i      = 1'b0;
  logic        rst_i      = 1'b1;
  logic        wb_cyc_i   = 1'b0;
  logic        wb_stb_i   = 1'b0;
  logic        wb_we_i    = 1'b0;
  logic [11:0] wb_adr_i   = 12'h000;
  logic [3:0]  wb_sel_i   = 4'h0;
  logic [31:0] wb_dat_i   = 32'h0000_0000;
  logic        dbl_en     = 1'b0;
  logic [3:0]  run        = 4'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        conflict;
  logic [3:0]  pins;
  logic [3:0]  lock_edge;
  logic [3:0]  mon_edge;
  logic [3:0]  valid;
  logic [7:0]  amp;
  logic [3:0]  trim_lo;
  logic [3:0]  trim_hi;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          n_lock [4] = '{default: 0};
  int          n_mon  [4] = '{default: 0};

  icf_input_front #(.MISS_LIMIT(MISS)) DUT (
    .clk_i                       (clk_i),
    .rst_i                       (rst_i),
    .wb_cyc_i                    (wb_cyc_i),
    .wb_stb_i                    (wb_stb_i),
    .wb_we_i                     (wb_we_i),
    .wb_adr_i                    (wb_adr_i),
    .wb_sel_i                    (wb_sel_i),
    .wb_dat_i                    (wb_dat_i),
    .wb_dat_o                    (wb_dat_o),
    .wb_ack_o                    (wb_ack_o),
    .oscillator_input_pin_i      (pins[0]),
    .reference_clock_input_n_i   (pins[3:1]),
    .oscillator_doubler_enable_i (dbl_en),
    .lock_edge_o                 (lock_edge),
    .monitor_edge_o              (mon_edge),
    .input_valid_o               (valid),
    .crystal_amp_setting_o       (amp),
    .first_pin_load_trim_o       (trim_lo),
    .second_pin_load_trim_o      (trim_hi),
    .prescale_doubler_conflict_o (conflict)
  );

  icf_ref_sources src (
    .run_i  (run),
    .pins_o (pins)
  );

  initial begin
    forever begin
      #12.5 clk_i = ~clk_i;
    end
  end

  // pulses last one cycle, so counting mid-cycle sees each exactly once
  always @(negedge clk_i) begin
    for (int k = 0; k < 4; k++) begin
      n_lock[k] += int'(lock_edge[k] === 1'b1);
      n_mon[k]  += int'(mon_edge[k] === 1'b1);
    end
  end

  // =====================================================================
  // helpers
  // =====================================================================
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic near(input int a, input int b, input int tol);
    return (a - b <= tol) && (b - a <= tol);
  endfunction : near

  // index 6 lies past the map
  task automatic wb(input logic we, input int idx, input logic [7:0] d, input logic [3:0] sel,
                    output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= 12'hC00 + 12'(idx * 4);
    wb_sel_i <= sel;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    check("bus answer cycles", n, 32'h2);
    check("read upper bits", {8'h00, wb_dat_o[31:8]}, 32'h0);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb

  // =====================================================================
  // scenarios
  // =====================================================================
  task automatic t_regs();
    logic [7:0] q;
    logic [7:0] pat [2] = '{8'hFF, 8'hA5};
    check("outputs after reset", {12'h0, amp, trim_hi, trim_lo, valid}, 32'h0);
    for (int i = 0; i < 7; i++) begin
      wb(1'b0, i, 8'h00, 4'h1, q);
      check("reset value", {24'h0, q}, 32'h0);
    end
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 6; i++) begin
        wb(1'b1, i, pat[p], 4'h1, q);
        wb(1'b0, i, 8'h00, 4'h1, q);
        check("readback", {24'h0, q}, {24'h0, (i == 1 || i == 2) ? pat[p] : pat[p] & `ICF_CFG_MASK});
      end
    end
    check("amplifier setting", {24'h0, amp}, 32'hA5);
    check("first pin trim", {28'h0, trim_lo}, 32'h5);
    check("second pin trim", {28'h0, trim_hi}, 32'hA);
    wb(1'b1, 6, 8'h5A, 4'h1, q);
    wb(1'b0, 6, 8'h00, 4'h1, q);
    check("unmapped read", {24'h0, q}, 32'h0);
    wb(1'b1, 1, 8'h3C, 4'h0, q);
    wb(1'b0, 1, 8'h00, 4'h1, q);
    check("masked lane write", {24'h0, q}, 32'hA5);
  endtask : t_regs

  task automatic t_conflict();
    logic [7:0] q;
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < 4; c++) begin
        @(posedge clk_i);
        dbl_en <= b[0];
        wb(1'b1, 0, {6'h00, 2'(c)}, 4'h1, q);
        repeat (3) @(negedge clk_i);
        check("doubler conflict", {31'h0, conflict}, 32'(b == 1 && c == 1));
      end
    end
    @(posedge clk_i);
    dbl_en <= 1'b0;
  endtask : t_conflict

  // e bit 1 selects the falling edge, e bit 0 withholds the monitor feed
  task automatic t_edges();
    logic [7:0] q;
    int         l0;
    int         m0;
    @(posedge clk_i);
    run <= 4'h0;
    repeat (10) @(posedge clk_i);
    for (int k = 0; k < 4; k++) begin
      for (int e = 0; e < 4; e++) begin
        wb(1'b1, k == 0 ? 0 : k + 2, {1'b0, e[1], e[0], 5'h00}, 4'h1, q);
        if (pins[k] === 1'b1) begin
          src.flip(k);
          repeat (10) @(posedge clk_i);
        end
        for (int s = 0; s < 2; s++) begin
          l0 = n_lock[k];
          m0 = n_mon[k];
          src.flip(k);
          repeat (10) @(posedge clk_i);
          check("lock edge count", n_lock[k] - l0, 32'(s == e[1]));
          check("monitor edge count", n_mon[k] - m0, 32'(s == e[1] && e[0] == 0));
        end
      end
    end
  endtask : t_edges

  task automatic t_prescale();
    logic [7:0] q;
    int         l0;
    int         m0;
    int         d;
    @(posedge clk_i);
    run <= 4'hF;
    for (int k = 0; k < 4; k++) begin
      for (int c = 0; c < 4; c++) begin
        wb(1'b1, k == 0 ? 0 : k + 2, 8'(c), 4'h1, q);
        d = (k == 0) ? ((c == 1) ? 2 : 1) : (1 << c);
        repeat (8) @(posedge clk_i);
        l0 = n_lock[k];
        m0 = n_mon[k];
        repeat (600) @(posedge clk_i);
        check("prescale ratio", {31'h0, near((n_lock[k] - l0) * d, n_mon[k] - m0, d)}, 32'h1);
      end
    end
  endtask : t_prescale

  // validation window on clock input two
  task automatic t_window();
    logic [7:0] q;
    int         m0;
    int         n;
    int         len [8] = '{1, 4, 16, 64, 256, 1024, 1024, 1024};
    wb(1'b1, 4, 8'h20, 4'h1, q);
    repeat (100) @(posedge clk_i);
    check("valid without feed", {31'h0, valid[2]}, 32'h0);
    for (int c = 0; c < 8; c++) begin
      @(posedge clk_i);
      run <= 4'h0;
      n = 0;
      while (valid[2] !== 1'b0 && n < MISS + 20) begin
        @(negedge clk_i);
        n++;
      end
      check("valid drop on missing edges", {31'h0, valid[2]}, 32'h0);
      wb(1'b1, 4, {3'h0, 3'(c), 2'h0}, 4'h1, q);
      repeat (MISS + 4) @(posedge clk_i);
      m0 = n_mon[2];
      run <= 4'hF;
      n = 0;
      while (valid[2] !== 1'b1 && n < 20000) begin
        @(negedge clk_i);
        n++;
      end
      check("edges before valid", {31'h0, near(n_mon[2] - m0, len[c], 1)}, 32'h1);
    end
  endtask : t_window

  // =====================================================================
  // run control
  // =====================================================================
  task automatic tally_and_finish();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // the window scenario dominates at roughly 31k cycles
  initial begin
    repeat (100000) @(posedge clk_i);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_conflict();
    t_edges();
    t_prescale();
    t_window();
    tally_and_finish();
  end
endmodule : icf_input_front_bench
